//--- mdio_pkg.sv
// constants shared by the motor driver i/o command logic
// assumes a single 100 MHz core clock and active-low async reset
package mdio_pkg;
  // core clock
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
  // time units of the settings, in their own unit
  localparam int unsigned OVL_UNIT_MS = 100; // overload threshold lsb, 0.1 s
  localparam int unsigned COMM_UNIT_MS = 1; // link timeout lsb
  localparam int unsigned BLINK_HALF_MS = 250; // fault indicator half period
  // derived cycle counts, all above 4096 so the top exposes them
  localparam int unsigned OVL_TICK_CYC = OVL_UNIT_MS * CLK_KHZ;
  localparam int unsigned COMM_TICK_CYC = COMM_UNIT_MS * CLK_KHZ;
  localparam int unsigned BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;
  // synchronised host input positions
  localparam int NI = 11;
  localparam int I_JOGP = 0;
  localparam int I_JOGN = 1;
  localparam int I_STOP = 2;
  localparam int I_EXCD = 3;
  localparam int I_EXCN = 4;
  localparam int I_FREE = 5;
  localparam int I_PRST = 6;
  localparam int I_FCLR = 7;
  localparam int I_PCLR = 8;
  localparam int I_UNLD = 9;
  localparam int I_UNLN = 10;
  // fault bit positions
  localparam int NF = 6;
  localparam int F_OVL = 0;
  localparam int F_DEV = 1;
  localparam int F_HOME = 2;
  localparam int F_COMM = 3;
  localparam int F_ABS = 4;
  localparam int F_HARD = 5;
  // faults the fault-clear input may reset
  localparam logic [NF-1:0] FCLR_MASK = 6'h0F;
  // setting defaults
  localparam logic [22:0] JOG_TRAVEL_RST = 23'h000001;
  localparam logic [19:0] JOG_SPEED_RST = 20'h003E8;
  localparam logic [19:0] JOG_START_RST = 20'h001F4;
  localparam logic [19:0] JOG_ACCEL_RST = 20'h003E8;
  localparam logic [1:0] STOP_ACT_RST = 2'h1;
  localparam logic [23:0] PRESET_RST = 24'h000000;
  localparam logic [8:0] OVL_LIM_RST = 9'h032;
  localparam logic [14:0] DEV_ON_RST = 15'h012C;
  localparam logic [14:0] DEV_OFF_RST = 15'h2710;
  localparam logic [3:0] COMM_ERR_RST = 4'h3;
  // stop actions
  localparam logic [1:0] STOP_IMM = 2'h0;
  localparam logic [1:0] STOP_DEC = 2'h1;
  // jog sequencer states
  typedef enum logic [2:0] {
    JOG_IDLE = 3'b001,
    JOG_RUN = 3'b010,
    JOG_DECEL = 3'b100
  } mdio_jog_t;
endpackage

//--- mdio_edge_if.sv
// carrier between the input conditioner and the command logic
// assumes raw side comes from device pins on another time base
`timescale 1ns/100ps
interface mdio_edge_if #(parameter int N = 1);
  logic [N-1:0] raw; // unsynchronised pins
  logic [N-1:0] lvl; // synchronised level
  logic [N-1:0] rise; // one-cycle off-to-on pulse
  logic [N-1:0] fall; // one-cycle on-to-off pulse
  modport cond (input raw, output lvl, output rise, output fall);
  modport user (output raw, input lvl, input rise, input fall);
endinterface

//--- mdio_sync.sv
// two-flop synchroniser and edge detector for a vector of pins
// assumes raw pins are asynchronous to clock
`timescale 1ns/100ps
module mdio_sync #(parameter int N = 1) (
  input wire logic clock,
  input wire logic nrst,
  mdio_edge_if.cond e
);
  logic [N-1:0] s1_q, s1_d; // first stage, read only by s2
  logic [N-1:0] s2_q, s2_d; // settled level
  logic [N-1:0] pv_q, pv_d; // previous settled sample

  // next values; edges come from settled samples only
  always_comb begin
    s1_d = e.raw;
    s2_d = s1_q;
    pv_d = s2_q;
  end

  // registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      pv_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      pv_q <= pv_d;
    end
  end

  assign e.lvl = s2_q;
  assign e.rise = s2_q & ~pv_q;
  assign e.fall = ~s2_q & pv_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_edge_once: assert property (e.rise[0] |=> !e.rise[0])
    else $error("rise pulse longer than one cycle");
endmodule

//--- mdio_top.sv
// stepping motor driver i/o command logic: jog, stop, excitation, preset, faults
// assumes host pins are asynchronous; status inputs come from core-clock logic
`timescale 1ns/100ps
module mdio_top #(
  parameter int unsigned OVL_TICK = mdio_pkg::OVL_TICK_CYC,
  parameter int unsigned COMM_TICK = mdio_pkg::COMM_TICK_CYC,
  parameter int unsigned BLINK = mdio_pkg::BLINK_CYC
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic manual_step_pos_input,
  input wire logic manual_step_neg_input,
  input wire logic stop_input,
  input wire logic excite_dir_input,
  input wire logic excite_net_input,
  input wire logic excite_dir_mapped,
  input wire logic excite_net_mapped,
  input wire logic free_run_input,
  input wire logic pos_load_input,
  input wire logic fault_clear_input,
  input wire logic abs_pos_fault_clear_input,
  input wire logic operator_unlock_dir_input,
  input wire logic operator_unlock_net_input,
  input wire logic unlock_dir_mapped,
  input wire logic unlock_net_mapped,
  input wire logic [22:0] jog_travel,
  input wire logic [19:0] jog_speed,
  input wire logic [19:0] jog_start_speed,
  input wire logic [19:0] jog_accel,
  input wire logic [1:0] stop_action,
  input wire logic [23:0] preset_value,
  input wire logic [8:0] overload_limit,
  input wire logic [14:0] dev_limit_on,
  input wire logic [14:0] dev_limit_off,
  input wire logic home_check_en,
  input wire logic [13:0] link_timeout_ms,
  input wire logic [3:0] link_err_limit,
  input wire logic caution_nc,
  input wire logic overload_flag,
  input wire logic [14:0] deviation,
  input wire logic position_start,
  input wire logic origin_set,
  input wire logic position_busy,
  input wire logic link_error,
  input wire logic link_frame,
  input wire logic abs_pos_error,
  input wire logic hard_fault,
  input wire logic [7:0] warning_flags,
  output logic step_pulse,
  output logic step_dir,
  output logic [23:0] command_position,
  output logic position_abort,
  output logic motor_current_en,
  output logic brake_release,
  output logic [5:0] fault_bits,
  output logic fault_output_dir,
  output logic fault_output_net,
  output logic fault_indicator,
  output logic caution_output_dir,
  output logic caution_output_net,
  output logic tools_permit,
  output logic moving
);
  mdio_edge_if #(.N(mdio_pkg::NI)) e (); // conditioned host inputs

  assign e.raw = {operator_unlock_net_input, operator_unlock_dir_input, abs_pos_fault_clear_input,
                  fault_clear_input, pos_load_input, free_run_input, excite_net_input,
                  excite_dir_input, stop_input, manual_step_neg_input, manual_step_pos_input};

  mdio_sync #(.N(mdio_pkg::NI)) u_sync (.clock(clock), .nrst(nrst), .e(e));

  // effective excitation and unlock: unmapped means on, both mapped means and
  logic exc_eff, unl_eff;
  assign exc_eff = (excite_dir_mapped ? e.lvl[mdio_pkg::I_EXCD] : 1'b1)
                 & (excite_net_mapped ? e.lvl[mdio_pkg::I_EXCN] : 1'b1);
  assign unl_eff = (unlock_dir_mapped ? e.lvl[mdio_pkg::I_UNLD] : 1'b1)
                 & (unlock_net_mapped ? e.lvl[mdio_pkg::I_UNLN] : 1'b1);

  logic [mdio_pkg::NF-1:0] fault_q, fault_d; // sticky fault flags
  logic fault_any;
  assign fault_any = |fault_q;

  // jog sequencer state
  mdio_pkg::mdio_jog_t st_q, st_d;
  logic [22:0] rem_q, rem_d; // steps left in this jog
  logic [19:0] spd_q, spd_d; // present step rate in Hz
  logic [27:0] acc_q, acc_d; // rate accumulator for step timing
  logic [19:0] ramp_q, ramp_d; // ns accumulated toward one Hz of ramp
  logic dir_q, dir_d; // 1 = positive
  logic fire; // a step is issued this cycle
  logic jog_ok;
  logic [27:0] acc_sum;
  logic ramp_hit;

  assign jog_ok = !fault_any && exc_eff && !e.lvl[mdio_pkg::I_FREE] && !e.lvl[mdio_pkg::I_STOP]
                && !position_busy;

  // jog next state: start, run at ramped rate, stop or decelerate
  always_comb begin
    st_d = st_q;
    rem_d = rem_q;
    spd_d = spd_q;
    acc_d = acc_q;
    ramp_d = ramp_q;
    dir_d = dir_q;
    fire = 1'b0;
    acc_sum = acc_q + 28'(spd_q);
    ramp_hit = (ramp_q + 20'(mdio_pkg::CLK_NS)) >= jog_accel;
    case (st_q)
      mdio_pkg::JOG_IDLE: begin
        // both jog edges together is ambiguous, so neither starts
        if (jog_ok && (e.rise[mdio_pkg::I_JOGP] ^ e.rise[mdio_pkg::I_JOGN])) begin
          st_d = mdio_pkg::JOG_RUN;
          dir_d = e.rise[mdio_pkg::I_JOGP];
          rem_d = (jog_travel == 23'h000000) ? 23'h000001 : jog_travel;
          spd_d = (jog_start_speed == 20'h00000) ? 20'h00001 : jog_start_speed;
          acc_d = 28'h0000000;
          ramp_d = 20'h00000;
        end
      end
      mdio_pkg::JOG_RUN, mdio_pkg::JOG_DECEL: begin
        // step when the accumulator wraps one second of clock
        if (acc_sum >= 28'(mdio_pkg::CLK_HZ)) begin
          acc_d = acc_sum - 28'(mdio_pkg::CLK_HZ);
          fire = 1'b1;
          rem_d = rem_q - 23'h000001;
        end else begin
          acc_d = acc_sum;
        end
        // ramp: one Hz per accel ns, since 1 unit = 1 ns per Hz
        ramp_d = ramp_hit ? 20'h00000 : ramp_q + 20'(mdio_pkg::CLK_NS);
        if (ramp_hit && st_q == mdio_pkg::JOG_RUN && spd_q < jog_speed)
          spd_d = spd_q + 20'h00001;
        if (ramp_hit && st_q == mdio_pkg::JOG_DECEL)
          spd_d = spd_q - 20'h00001;
        if (fire && rem_q == 23'h000001)
          st_d = mdio_pkg::JOG_IDLE; // travel done
        else if (st_q == mdio_pkg::JOG_DECEL && spd_q <= jog_start_speed + 20'h00001)
          st_d = mdio_pkg::JOG_IDLE; // decel finished, remainder dropped
        else if (e.lvl[mdio_pkg::I_STOP] && st_q == mdio_pkg::JOG_RUN)
          st_d = stop_action[0] ? mdio_pkg::JOG_DECEL : mdio_pkg::JOG_IDLE;
        // fault or free stops at once, no step this cycle
        if (fault_any || e.lvl[mdio_pkg::I_FREE] || !exc_eff) begin
          st_d = mdio_pkg::JOG_IDLE;
          fire = 1'b0;
          rem_d = rem_q;
        end
      end
      default: st_d = mdio_pkg::JOG_IDLE;
    endcase
  end

  // jog registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q <= mdio_pkg::JOG_IDLE;
      rem_q <= 23'h000000;
      spd_q <= 20'h00000;
      acc_q <= 28'h0000000;
      ramp_q <= 20'h00000;
      dir_q <= 1'b1;
    end else begin
      st_q <= st_d;
      rem_q <= rem_d;
      spd_q <= spd_d;
      acc_q <= acc_d;
      ramp_q <= ramp_d;
      dir_q <= dir_d;
    end
  end

  // position and output drive state
  logic [23:0] pos_q, pos_d; // command position, signed
  logic step_q, step_d;
  logic abort_q, abort_d;
  logic cur_q, cur_d; // winding current on
  logic brk_q, brk_d; // brake released
  logic moving_d, moving_q;
  logic stop_cut; // stop action with current removal, held while stop stays on

  assign stop_cut = e.lvl[mdio_pkg::I_STOP] && stop_action[1] && st_q == mdio_pkg::JOG_IDLE;

  // position, step, current and brake next values
  always_comb begin
    pos_d = pos_q;
    if (fire)
      pos_d = dir_q ? pos_q + 24'h000001 : pos_q - 24'h000001;
    // preset only when healthy and still
    if (e.rise[mdio_pkg::I_PRST] && !fault_any && !moving_q && st_q == mdio_pkg::JOG_IDLE)
      pos_d = preset_value;
    step_d = fire;
    // remainder of an external positioning move is discarded
    abort_d = e.rise[mdio_pkg::I_STOP] && position_busy;
    // windings follow excitation unless freed, faulted or stop-cut
    cur_d = exc_eff && !e.lvl[mdio_pkg::I_FREE] && !fault_any && !stop_cut;
    // brake opens on free, or only once current has been on a cycle
    brk_d = e.lvl[mdio_pkg::I_FREE] || (cur_q && cur_d);
    moving_d = (st_d != mdio_pkg::JOG_IDLE) || position_busy;
  end

  // position and drive registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_q <= mdio_pkg::PRESET_RST;
      step_q <= 1'b0;
      abort_q <= 1'b0;
      cur_q <= 1'b0;
      brk_q <= 1'b0;
      moving_q <= 1'b0;
    end else begin
      pos_q <= pos_d;
      step_q <= step_d;
      abort_q <= abort_d;
      cur_q <= cur_d;
      brk_q <= brk_d;
      moving_q <= moving_d;
    end
  end

  // fault monitoring state
  logic [31:0] ovl_pre_q, ovl_pre_d; // 0.1 s prescaler while overloaded
  logic [8:0] ovl_cnt_q, ovl_cnt_d; // elapsed 0.1 s units
  logic [31:0] ms_pre_q, ms_pre_d; // 1 ms prescaler since last frame
  logic [13:0] ms_cnt_q, ms_cnt_d; // silent link ms
  logic [3:0] err_cnt_q, err_cnt_d; // link errors seen
  logic [mdio_pkg::NF-1:0] set_v, clr_v;

  // fault detection, then set wins over clear
  always_comb begin
    set_v = '0;
    clr_v = '0;
    ovl_pre_d = ovl_pre_q;
    ovl_cnt_d = ovl_cnt_q;
    if (!overload_flag) begin
      ovl_pre_d = 32'h00000000;
      ovl_cnt_d = 9'h000;
    end else if (ovl_pre_q >= 32'(OVL_TICK - 1)) begin
      ovl_pre_d = 32'h00000000;
      if (ovl_cnt_q != 9'h1FF)
        ovl_cnt_d = ovl_cnt_q + 9'h001;
    end else begin
      ovl_pre_d = ovl_pre_q + 32'h00000001;
    end
    set_v[mdio_pkg::F_OVL] = overload_flag && ovl_cnt_q >= overload_limit;
    // threshold follows present excitation
    set_v[mdio_pkg::F_DEV] = deviation > (cur_q ? dev_limit_on : dev_limit_off);
    set_v[mdio_pkg::F_HOME] = home_check_en && position_start && !origin_set;
    // link timeout, zero setting disables
    ms_pre_d = ms_pre_q;
    ms_cnt_d = ms_cnt_q;
    if (link_frame || link_timeout_ms == 14'h0000) begin
      ms_pre_d = 32'h00000000;
      ms_cnt_d = 14'h0000;
    end else if (ms_pre_q >= 32'(COMM_TICK - 1)) begin
      ms_pre_d = 32'h00000000;
      if (ms_cnt_q != 14'h3FFF)
        ms_cnt_d = ms_cnt_q + 14'h0001;
    end else begin
      ms_pre_d = ms_pre_q + 32'h00000001;
    end
    err_cnt_d = err_cnt_q;
    if (link_error && err_cnt_q != 4'hF)
      err_cnt_d = err_cnt_q + 4'h1;
    set_v[mdio_pkg::F_ABS] = abs_pos_error;
    set_v[mdio_pkg::F_HARD] = hard_fault;
    if (e.fall[mdio_pkg::I_FCLR]) begin
      clr_v = mdio_pkg::FCLR_MASK;
      err_cnt_d = {3'h0, link_error}; // an error in the clear cycle still counts
      ms_cnt_d = 14'h0000;
    end
    // judged on the next counts, so a clear is not undone by the stale count
    set_v[mdio_pkg::F_COMM] = (link_timeout_ms != 14'h0000 && ms_cnt_d >= link_timeout_ms)
                            || (err_cnt_d >= link_err_limit && link_err_limit != 4'h0);
    if (e.fall[mdio_pkg::I_PCLR])
      clr_v[mdio_pkg::F_ABS] = 1'b1;
    fault_d = (fault_q & ~clr_v) | set_v;
  end

  // fault registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_q <= '0;
      ovl_pre_q <= 32'h00000000;
      ovl_cnt_q <= 9'h000;
      ms_pre_q <= 32'h00000000;
      ms_cnt_q <= 14'h0000;
      err_cnt_q <= 4'h0;
    end else begin
      fault_q <= fault_d;
      ovl_pre_q <= ovl_pre_d;
      ovl_cnt_q <= ovl_cnt_d;
      ms_pre_q <= ms_pre_d;
      ms_cnt_q <= ms_cnt_d;
      err_cnt_q <= err_cnt_d;
    end
  end

  // status outputs: blink timer and encoded fault, caution, unlock
  logic [31:0] blk_q, blk_d;
  logic led_q, led_d;
  logic fdir_q, fdir_d, fnet_q, fnet_d;
  logic cdir_q, cdir_d, cnet_q, cnet_d;
  logic perm_q, perm_d;

  always_comb begin
    blk_d = (!fault_any || blk_q >= 32'(BLINK - 1)) ? 32'h00000000 : blk_q + 32'h00000001;
    led_d = !fault_any ? 1'b0 : (blk_q >= 32'(BLINK - 1)) ? !led_q : led_q;
    fdir_d = !fault_any; // closed type: conducting while healthy
    fnet_d = fault_any;
    cnet_d = |warning_flags;
    cdir_d = caution_nc ? !(|warning_flags) : |warning_flags;
    perm_d = unl_eff;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      blk_q <= 32'h00000000;
      led_q <= 1'b0;
      fdir_q <= 1'b0;
      fnet_q <= 1'b0;
      cdir_q <= 1'b0;
      cnet_q <= 1'b0;
      perm_q <= 1'b0;
    end else begin
      blk_q <= blk_d;
      led_q <= led_d;
      fdir_q <= fdir_d;
      fnet_q <= fnet_d;
      cdir_q <= cdir_d;
      cnet_q <= cnet_d;
      perm_q <= perm_d;
    end
  end

  assign step_pulse = step_q;
  assign step_dir = dir_q;
  assign command_position = pos_q;
  assign position_abort = abort_q;
  assign motor_current_en = cur_q;
  assign brake_release = brk_q;
  assign fault_bits = fault_q;
  assign fault_output_dir = fdir_q;
  assign fault_output_net = fnet_q;
  assign fault_indicator = led_q;
  assign caution_output_dir = cdir_q;
  assign caution_output_net = cnet_q;
  assign tools_permit = perm_q;
  assign moving = moving_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  a_jog_pos_start: assert property (st_q == mdio_pkg::JOG_IDLE && jog_ok && e.rise[mdio_pkg::I_JOGP]
    && !e.rise[mdio_pkg::I_JOGN] |=> st_q == mdio_pkg::JOG_RUN && dir_q)
    else $error("jog did not start positive");
  a_brake_after_cur: assert property (brake_release && !$past(free_run_input, 3)
    && !e.lvl[mdio_pkg::I_FREE] |-> $past(motor_current_en))
    else $error("brake released before excitation");
  a_fault_cuts_cur: assert property (fault_any |=> !motor_current_en && st_q == mdio_pkg::JOG_IDLE)
    else $error("fault left current on");
  a_fault_outputs: assert property (fault_any |=> !fault_output_dir && fault_output_net)
    else $error("fault outputs wrong polarity");
  a_preset_load: assert property (e.rise[mdio_pkg::I_PRST] && !fault_any && !moving_q
    && st_q == mdio_pkg::JOG_IDLE |=> command_position == $past(preset_value))
    else $error("preset not loaded");
  a_preset_block: assert property (e.rise[mdio_pkg::I_PRST] && fault_any |=> $stable(command_position))
    else $error("preset taken during fault");
  a_fclr_resets: assert property (e.fall[mdio_pkg::I_FCLR] && set_v == '0
    |=> (fault_bits & mdio_pkg::FCLR_MASK) == '0 ##1 fault_output_dir || fault_any)
    else $error("fault clear ignored");
  a_pclr_only_abs: assert property (e.fall[mdio_pkg::I_PCLR] && !e.fall[mdio_pkg::I_FCLR] && set_v == '0
    |=> fault_q == ($past(fault_q) & 6'h2F))
    else $error("abs clear touched other faults");
  a_excite_free: assert property (!excite_dir_mapped && !excite_net_mapped && !e.lvl[mdio_pkg::I_FREE]
    && !fault_any && !stop_cut |=> motor_current_en)
    else $error("unmapped excitation not on");
  a_free_cuts: assert property (e.lvl[mdio_pkg::I_FREE] |=> !motor_current_en && brake_release)
    else $error("free did not cut current");
  a_unlock_gate: assert property (unlock_dir_mapped && !e.lvl[mdio_pkg::I_UNLD] |=> !tools_permit)
    else $error("tools permitted while locked");
  a_caution_any: assert property ((|warning_flags) |=> caution_output_net)
    else $error("warning not shown");
  c_jog_done: cover property (st_q == mdio_pkg::JOG_RUN ##1 st_q == mdio_pkg::JOG_IDLE);
  c_decel_stop: cover property (st_q == mdio_pkg::JOG_DECEL);
  c_fault_clear: cover property (fault_any ##1 e.fall[mdio_pkg::I_FCLR] ##1 !fault_any);
endmodule

//--- mdio_host.sv
// host controller model: drives the jog, stop, excite, preset, clear and unlock pins
// assumes bit order of host_pins follows the input positions in mdio_pkg
`timescale 1ns/100ps
module mdio_host (
  input wire logic clock,
  output logic [10:0] host_pins
);
  initial host_pins = 11'h000; // all pins off at power-up
  // change after falling edge, then hold long enough for sync and edge register
  task automatic set_pin(input int idx, input logic val);
    @(negedge clock);
    host_pins[idx] = val;
    repeat (6) @(negedge clock);
  endtask
  // on then off, each level held, so both edges are seen once
  task automatic pulse(input int idx);
    set_pin(idx, 1'b1);
    set_pin(idx, 1'b0);
  endtask
endmodule

//--- mdio_top_tb_top.sv
// self-checking bench for the i/o command logic, host pins from mdio_host
// assumes short tick parameters so fault timers stay brief
`timescale 1ns/100ps
module mdio_top_tb_top;
  logic clock = 1'b0, nrst = 1'b0;
  logic excite_dir_mapped = 1'b0, excite_net_mapped = 1'b0, unlock_dir_mapped = 1'b0, unlock_net_mapped = 1'b0;
  logic [22:0] jog_travel = mdio_pkg::JOG_TRAVEL_RST;
  logic [19:0] jog_speed = 20'hF4240, jog_start_speed = 20'hF4240, jog_accel = mdio_pkg::JOG_ACCEL_RST;
  logic [1:0] stop_action = mdio_pkg::STOP_ACT_RST;
  logic [23:0] preset_value = 24'h000000;
  logic [8:0] overload_limit = 9'h002; // 20 cycles with a tick of 10
  logic [14:0] dev_limit_on = mdio_pkg::DEV_ON_RST, dev_limit_off = mdio_pkg::DEV_OFF_RST, deviation = 15'h0000;
  logic [13:0] link_timeout_ms = 14'h0000;
  logic [3:0] link_err_limit = mdio_pkg::COMM_ERR_RST;
  logic home_check_en = 1'b0, caution_nc = 1'b0, overload_flag = 1'b0, position_start = 1'b0, origin_set = 1'b0;
  logic position_busy = 1'b0, link_error = 1'b0, link_frame = 1'b0, abs_pos_error = 1'b0, hard_fault = 1'b0;
  logic [7:0] warning_flags = 8'h00;
  logic step_pulse, step_dir, position_abort, motor_current_en, brake_release, fault_output_dir;
  logic fault_output_net, fault_indicator, caution_output_dir, caution_output_net, tools_permit, moving;
  logic [23:0] command_position;
  logic [5:0] fault_bits;
  logic [10:0] host_pins;
  wire logic operator_unlock_net_input, operator_unlock_dir_input, abs_pos_fault_clear_input;
  wire logic fault_clear_input, pos_load_input, free_run_input, excite_net_input, excite_dir_input;
  wire logic stop_input, manual_step_neg_input, manual_step_pos_input;
  int fails = 0, n_checks = 0, n_abort = 0;
  // abort pulses counted on the falling edge, one count per pulse
  always @(negedge clock) if (position_abort === 1'b1) n_abort++;
  // pins split in the order of the input positions
  assign {operator_unlock_net_input, operator_unlock_dir_input, abs_pos_fault_clear_input, fault_clear_input,
    pos_load_input, free_run_input, excite_net_input, excite_dir_input, stop_input, manual_step_neg_input,
    manual_step_pos_input} = host_pins;
  mdio_host host (.clock(clock), .host_pins(host_pins));
  mdio_top #(.OVL_TICK(10), .COMM_TICK(10), .BLINK(4)) i_dut (.*);
  always #5 clock = ~clock; // 100 MHz
  // compare and count
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one jog of one step; bounded wait for the step pulse
  task automatic jog(input int idx, input logic [23:0] pos, input logic dir);
    int n;
    n = 0;
    host.set_pin(idx, 1'b1);
    while (step_pulse !== 1'b1 && n < 3000) begin
      @(posedge clock);
      #1 n++;
    end
    check("step seen", {23'h0, step_pulse}, 24'h1);
    check("step dir", {23'h0, step_dir}, {23'h0, dir});
    check("jog position", command_position, pos);
    host.set_pin(idx, 1'b0);
  endtask
  task automatic t_jog();
    jog(mdio_pkg::I_JOGP, 24'h000001, 1'b1);
    jog(mdio_pkg::I_JOGN, 24'h000000, 1'b0);
  endtask
  // excitation mapping, brake order, free run
  task automatic t_excite();
    check("current unmapped", {23'h0, motor_current_en}, 24'h1);
    excite_dir_mapped = 1'b1;
    cyc(4);
    check("current pin off", {23'h0, motor_current_en}, 24'h0);
    check("brake pin off", {23'h0, brake_release}, 24'h0);
    host.set_pin(mdio_pkg::I_EXCD, 1'b1);
    check("current pin on", {23'h0, motor_current_en}, 24'h1);
    check("brake after excite", {23'h0, brake_release}, 24'h1);
    host.set_pin(mdio_pkg::I_FREE, 1'b1);
    check("free current", {22'h0, motor_current_en, brake_release}, 24'h1);
    host.set_pin(mdio_pkg::I_FREE, 1'b0);
    excite_dir_mapped = 1'b0;
  endtask
  // preset taken when idle, refused while an external move runs
  task automatic t_preset();
    preset_value = 24'h000123;
    host.pulse(mdio_pkg::I_PRST);
    check("preset load", command_position, 24'h000123);
    position_busy = 1'b1;
    preset_value = 24'hFFF456;
    host.pulse(mdio_pkg::I_PRST);
    check("preset refused", command_position, 24'h000123);
    position_busy = 1'b0;
  endtask
  // fault raise and the two clear inputs
  task automatic t_faults();
    abs_pos_error = 1'b1;
    cyc(1);
    abs_pos_error = 1'b0;
    cyc(3);
    check("abs fault", {15'h0, fault_bits, fault_output_dir, fault_output_net, motor_current_en}, 24'h82);
    host.pulse(mdio_pkg::I_FCLR);
    check("abs kept", {18'h0, fault_bits}, 24'h10);
    host.pulse(mdio_pkg::I_PCLR);
    check("abs cleared", {17'h0, fault_bits, fault_output_dir}, 24'h1);
    home_check_en = 1'b1;
    position_start = 1'b1;
    cyc(1);
    position_start = 1'b0;
    cyc(3);
    check("home fault", {18'h0, fault_bits}, 24'h04);
    host.pulse(mdio_pkg::I_PCLR);
    check("home kept", {18'h0, fault_bits}, 24'h04);
    host.pulse(mdio_pkg::I_FCLR);
    check("home cleared", {18'h0, fault_bits}, 24'h00);
    overload_flag = 1'b1;
    cyc(15);
    check("ovl early", {18'h0, fault_bits}, 24'h00);
    cyc(25);
    check("ovl fault", {18'h0, fault_bits}, 24'h01);
    overload_flag = 1'b0;
    host.pulse(mdio_pkg::I_FCLR);
  endtask
  // unlock needs both copies when both mapped; warning outputs
  task automatic t_unlock_warn();
    check("unlock unmapped", {23'h0, tools_permit}, 24'h1);
    {unlock_dir_mapped, unlock_net_mapped} = 2'h3;
    host.set_pin(mdio_pkg::I_UNLD, 1'b1);
    check("unlock one copy", {23'h0, tools_permit}, 24'h0);
    host.set_pin(mdio_pkg::I_UNLN, 1'b1);
    check("unlock both", {23'h0, tools_permit}, 24'h1);
    warning_flags = 8'h04;
    cyc(4);
    check("caution", {22'h0, caution_output_dir, caution_output_net}, 24'h3);
    caution_nc = 1'b1;
    cyc(2);
    check("caution closed type", {22'h0, caution_output_dir, caution_output_net}, 24'h1);
    warning_flags = 8'h00;
  endtask
  // stop abort and current-off action, deviation limit with blink, link error count
  task automatic t_stop_link();
    position_busy = 1'b1;
    stop_action = 2'h2;
    host.set_pin(mdio_pkg::I_STOP, 1'b1);
    check("stop abort cut", {20'h0, n_abort[1:0], moving, motor_current_en}, 24'h6);
    position_busy = 1'b0;
    host.set_pin(mdio_pkg::I_STOP, 1'b0);
    check("stop released", {22'h0, moving, motor_current_en}, 24'h1);
    stop_action = mdio_pkg::STOP_ACT_RST;
    deviation = mdio_pkg::DEV_ON_RST;
    cyc(3);
    check("dev at limit", {18'h0, fault_bits}, 24'h00);
    deviation = mdio_pkg::DEV_ON_RST + 15'h0001;
    cyc(6);
    check("dev fault blink", {17'h0, fault_bits, fault_indicator}, 24'h05);
    cyc(4);
    check("blink off", {23'h0, fault_indicator}, 24'h0);
    deviation = 15'h0000;
    host.pulse(mdio_pkg::I_FCLR);
    link_error = 1'b1;
    cyc(2);
    check("link err early", {18'h0, fault_bits}, 24'h00);
    cyc(1);
    link_error = 1'b0;
    cyc(2);
    check("link err fault", {18'h0, fault_bits}, 24'h08);
    host.pulse(mdio_pkg::I_FCLR);
    check("link err cleared", {18'h0, fault_bits}, 24'h00);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    fails++;
    final_report();
  end
  initial begin
    repeat (16) @(negedge clock);
    nrst = 1;
    cyc(4);
    check("healthy out", {22'h0, fault_output_dir, fault_output_net}, 24'h2);
    t_excite();
    t_jog();
    t_preset();
    t_faults();
    t_unlock_warn();
    t_stop_link();
    final_report();
  end
endmodule
